// ### hw/rrb_pad_ctrl.v
// Relocatable register block decode with per-port pull-up and reduced-drive control
// Notes on behaviour
// RULE1: Register block may be moved to any 2K-aligned spot in 64K space.
// RULE2: Five-bit base field gives address bits 15 to 11 of the block.
// RULE3: Only lower 1K of the 2K window selects the register block.
// RULE4: After reset the block base is address zero.
// RULE5: Each port group has a writable pull-up enable bit.
// RULE6: Each drivable port group has a writable reduced-drive bit.
// RULE7: Bus port pins 3:2 always pulled up while they are inputs.
// RULE8: Serial port pins set as outputs never get the pull-up.
// RULE9: An enabled pull-up reaches only the pins configured as inputs.
// RULE10: Reset gives full drive; pull-ups off except port E and serial. The code also pulls bus port pins 3:2 up after reset while they are inputs.
`include "rrb_defines.vh"

module rrb_pad_ctrl
(
	input wire mclk, // System clock, 10 MHz
	input wire rst_n, // Synchronous reset, active low
	input wire [7:0] avs_address, // Register index
	input wire avs_read, // Read request
	input wire avs_write, // Write request
	input wire [31:0] avs_writedata, // Write data, low byte used
	input wire [3:0] avs_byteenable, // Byte lanes, lane 0 used
	output wire [31:0] avs_readdata, // Read data
	output wire avs_waitrequest, // Stall until answer ready
	input wire [15:0] cpu_addr, // Processor address to decode
	output wire reg_block_sel, // Address hits the register block
	output wire [9:0] reg_block_offset, // Offset inside the block
	output wire mem_map_stop_wait, // Stored mode bit of base register
	input wire [7:0] porta_dir, // Port A direction, 1 = output
	input wire [7:0] portb_dir, // Port B direction
	input wire [7:0] porte_dir, // Port E direction
	input wire [7:0] porth_dir, // Port H direction
	input wire [7:0] portj_dir, // Port J direction
	input wire [7:0] portk_dir, // Port K direction
	input wire [7:0] pwm_port_dir, // PWM port direction
	input wire [7:0] serial_port_dir, // Serial port direction
	input wire [7:0] timer_port_dir, // Timer port direction
	input wire [7:0] bus_port_dir, // Bus port direction
	output reg [7:0] porta_pullup, // Pad pull-up on per pin
	output reg [7:0] portb_pullup, // Pad pull-up on per pin
	output reg [7:0] porte_pullup, // Pad pull-up on per pin
	output reg [7:0] porth_pullup, // Pad pull-up on per pin
	output reg [7:0] portj_pullup, // Pad pull-up on per pin
	output reg [7:0] portk_pullup, // Pad pull-up on per pin
	output reg [7:0] pwm_port_pullup, // Pad pull-up on per pin
	output reg [7:0] serial_port_pullup, // Pad pull-up on per pin
	output reg [7:0] timer_port_pullup, // Pad pull-up on per pin
	output reg [7:0] bus_port_pullup, // Pad pull-up on per pin
	output wire porta_weak_drive, // Reduced drive, port A
	output wire portb_weak_drive, // Reduced drive, port B
	output wire porte_weak_drive, // Reduced drive, port E
	output wire porth_weak_drive, // Reduced drive, port H
	output wire portj_weak_drive, // Reduced drive, port J
	output wire portk_weak_drive, // Reduced drive, port K
	output wire pwm_port_weak_drive, // Reduced drive, PWM port
	output wire serial_port_weak_drive, // Reduced drive, serial port
	output wire timer_port_weak_drive, // Reduced drive, timer port
	output wire bus_port_weak_drive // Reduced drive, bus port
);

	reg [7:0] pullup_enable_r;
	reg [7:0] drive_strength_select_r;
	reg [7:0] block_base_select_r;
	reg [7:0] pwm_port_control_r;
	reg [7:0] timer_mask_two_r;
	reg [7:0] serial_port_control_two_r;
	reg [7:0] bus_port_pull_drive_r;
	reg ack_r;
	reg [7:0] rdata_r;
	reg [7:0] rdata_nxt;
	wire req;
	wire wr_en;
	wire [4:0] block_base;
	wire wr_pullup_enable;
	wire wr_drive_strength_select;
	wire wr_block_base_select;
	wire wr_pwm_port_control;
	wire wr_timer_mask_two;
	wire wr_serial_port_control_two;
	wire wr_bus_port_pull_drive;
	wire [7:0] porta_pullup_nxt;
	wire [7:0] portb_pullup_nxt;
	wire [7:0] porte_pullup_nxt;
	wire [7:0] porth_pullup_nxt;
	wire [7:0] portj_pullup_nxt;
	wire [7:0] portk_pullup_nxt;
	wire [7:0] pwm_port_pullup_nxt;
	wire [7:0] serial_port_pullup_nxt;
	wire [7:0] timer_port_pullup_nxt;
	wire [7:0] bus_port_pullup_nxt;

	// Pins that exist and can carry a pull-up
	localparam [7:0] PORTE_PULL_PINS = 8'h8F; // Pins 7 and 3..0; 6..4 have none
	localparam [7:0] PORTK_PINS = 8'h8F; // Pins 7 and 3..0 exist
	localparam [7:0] BUS_SW_PULL_PINS = 8'hF0; // Follow the enable bit
	localparam [7:0] BUS_FIXED_PULL_PINS = 8'h0C; // Pulled whenever input

	// Per-pin pull-up: enable gated by input direction
	function [7:0] rrb_pull;
		input en;
		input [7:0] dir;
		begin
			rrb_pull = {8{en}} & ~dir;
		end
	endfunction

	// Index match, shared by all write strobes
	function rrb_hit;
		input [7:0] addr;
		input [7:0] idx;
		begin
			rrb_hit = (addr == idx);
		end
	endfunction

	// One wait cycle, then the answer
	// The wait cycle lets read data come from a flop instead of the mux
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	assign wr_en = avs_write & ack_r & avs_byteenable[0];
	assign avs_readdata = {24'h00_0000, rdata_r};

	// Handshake flop
	always @(posedge mclk)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// Read mux; unmapped indexes answer zero
	always @*
	begin
		case (avs_address)
			`RRB_IDX_PULLUP_ENABLE: rdata_nxt = pullup_enable_r;
			`RRB_IDX_DRIVE_STRENGTH_SELECT: rdata_nxt = drive_strength_select_r;
			`RRB_IDX_BLOCK_BASE_SELECT: rdata_nxt = block_base_select_r;
			`RRB_IDX_PWM_PORT_CONTROL: rdata_nxt = pwm_port_control_r;
			`RRB_IDX_TIMER_MASK_TWO: rdata_nxt = timer_mask_two_r;
			`RRB_IDX_SERIAL_PORT_CONTROL_TWO: rdata_nxt = serial_port_control_two_r;
			`RRB_IDX_BUS_PORT_PULL_DRIVE: rdata_nxt = bus_port_pull_drive_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data captured in the wait cycle
	always @(posedge mclk)
	begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (avs_read & ~ack_r)
			rdata_r <= rdata_nxt;
	end

	// Write strobes; a write lands only at the edge after the one that ends the wait
	assign wr_pullup_enable = wr_en
		& rrb_hit(avs_address, `RRB_IDX_PULLUP_ENABLE);
	assign wr_drive_strength_select = wr_en
		& rrb_hit(avs_address, `RRB_IDX_DRIVE_STRENGTH_SELECT);
	assign wr_block_base_select = wr_en
		& rrb_hit(avs_address, `RRB_IDX_BLOCK_BASE_SELECT);
	assign wr_pwm_port_control = wr_en
		& rrb_hit(avs_address, `RRB_IDX_PWM_PORT_CONTROL);
	assign wr_timer_mask_two = wr_en
		& rrb_hit(avs_address, `RRB_IDX_TIMER_MASK_TWO);
	assign wr_serial_port_control_two = wr_en
		& rrb_hit(avs_address, `RRB_IDX_SERIAL_PORT_CONTROL_TWO);
	assign wr_bus_port_pull_drive = wr_en
		& rrb_hit(avs_address, `RRB_IDX_BUS_PORT_PULL_DRIVE);

	// Pull-up enables of ports A, B, E, H, J and K; unimplemented bits stay zero
	always @(posedge mclk)
	begin
		if (!rst_n)
			pullup_enable_r <= `RRB_RST_PULLUP_ENABLE; // RULE10
		else if (wr_pullup_enable)
			pullup_enable_r <= avs_writedata[7:0] & `RRB_MASK_PULLUP_ENABLE; // RULE5
	end

	// Reduced-drive selects of ports A, B, E, H, J and K
	always @(posedge mclk)
	begin
		if (!rst_n)
			drive_strength_select_r <= `RRB_RST_DRIVE_STRENGTH; // RULE10
		else if (wr_drive_strength_select)
			drive_strength_select_r <= avs_writedata[7:0] & `RRB_MASK_DRIVE_STRENGTH; // RULE6
	end

	// Block base field and stored mode bit; base comes up at zero
	always @(posedge mclk)
	begin
		if (!rst_n)
			block_base_select_r <= `RRB_RST_BLOCK_BASE; // RULE4
		else if (wr_block_base_select)
			block_base_select_r <= avs_writedata[7:0] & `RRB_MASK_BLOCK_BASE; // RULE1
	end

	// PWM port control, pull-up and reduced-drive bits among them
	always @(posedge mclk)
	begin
		if (!rst_n)
			pwm_port_control_r <= `RRB_RST_PWM_PORT;
		else if (wr_pwm_port_control)
			pwm_port_control_r <= avs_writedata[7:0] & `RRB_MASK_PWM_PORT; // RULE5
	end

	// Timer port pull-up and reduced-drive bits
	always @(posedge mclk)
	begin
		if (!rst_n)
			timer_mask_two_r <= `RRB_RST_TIMER_MASK_TWO;
		else if (wr_timer_mask_two)
			timer_mask_two_r <= avs_writedata[7:0] & `RRB_MASK_TIMER_MASK_TWO; // RULE6
	end

	// Serial port pull-up and reduced-drive bits; pull-up comes up on
	always @(posedge mclk)
	begin
		if (!rst_n)
			serial_port_control_two_r <= `RRB_RST_SERIAL_PORT_TWO; // RULE10
		else if (wr_serial_port_control_two)
			serial_port_control_two_r <= avs_writedata[7:0] & `RRB_MASK_SERIAL_PORT_TWO;
	end

	// Bus port pull-up and reduced-drive bits
	always @(posedge mclk)
	begin
		if (!rst_n)
			bus_port_pull_drive_r <= `RRB_RST_BUS_PORT;
		else if (wr_bus_port_pull_drive)
			bus_port_pull_drive_r <= avs_writedata[7:0] & `RRB_MASK_BUS_PORT;
	end

	// Block decode: base on bits 15..11, lower 1K only
	assign block_base = block_base_select_r[`RRB_BASE_HI:`RRB_BASE_LO];
	assign reg_block_sel = (cpu_addr[15:11] == block_base) & ~cpu_addr[10]; // RULE2 RULE3
	assign reg_block_offset = cpu_addr[9:0];
	assign mem_map_stop_wait = block_base_select_r[`RRB_BIT_MMSWAI];

	// Reduced-drive outputs straight from register bits
	assign porta_weak_drive = drive_strength_select_r[`RRB_BIT_PORTA]; // RULE6
	assign portb_weak_drive = drive_strength_select_r[`RRB_BIT_PORTB];
	assign porte_weak_drive = drive_strength_select_r[`RRB_BIT_PORTE];
	assign porth_weak_drive = drive_strength_select_r[`RRB_BIT_PORTH];
	assign portj_weak_drive = drive_strength_select_r[`RRB_BIT_PORTJ];
	assign portk_weak_drive = drive_strength_select_r[`RRB_BIT_PORTK];
	assign pwm_port_weak_drive = pwm_port_control_r[`RRB_BIT_PWM_WEAK];
	assign serial_port_weak_drive = serial_port_control_two_r[`RRB_BIT_SER_WEAK];
	assign timer_port_weak_drive = timer_mask_two_r[`RRB_BIT_TMR_WEAK];
	assign bus_port_weak_drive = bus_port_pull_drive_r[`RRB_BIT_BUS_WEAK];

	// Next pull-up pattern: enable bit gated by input direction, absent pins masked
	assign porta_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTA], porta_dir); // RULE9
	assign portb_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTB], portb_dir); // RULE5
	// Port E pins 1..0 are input-only, so their direction is forced to input
	assign porte_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTE],
		{porte_dir[7:2], 2'b00}) & PORTE_PULL_PINS;
	assign porth_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTH], porth_dir);
	assign portj_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTJ], portj_dir);
	assign portk_pullup_nxt = rrb_pull(pullup_enable_r[`RRB_BIT_PORTK],
		portk_dir) & PORTK_PINS;
	assign pwm_port_pullup_nxt = rrb_pull(pwm_port_control_r[`RRB_BIT_PWM_PULLUP],
		pwm_port_dir);
	// Serial pins driven as outputs lose the pull-up whatever the enable says
	assign serial_port_pullup_nxt = rrb_pull(serial_port_control_two_r[`RRB_BIT_SER_PULLUP],
		serial_port_dir); // RULE8
	assign timer_port_pullup_nxt = rrb_pull(timer_mask_two_r[`RRB_BIT_TMR_PULLUP],
		timer_port_dir);
	// Bus port: 7..4 follow the enable bit, 3..2 are pulled whenever they are inputs
	assign bus_port_pullup_nxt = (rrb_pull(bus_port_pull_drive_r[`RRB_BIT_BUS_PULLUP],
		bus_port_dir) & BUS_SW_PULL_PINS)
		| (rrb_pull(1'b1, bus_port_dir) & BUS_FIXED_PULL_PINS); // RULE7

	// Per-pin pull-ups, registered so the pads see no glitch from direction changes
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			porta_pullup <= 8'h00;
			portb_pullup <= 8'h00;
			porte_pullup <= 8'h00;
			porth_pullup <= 8'h00;
			portj_pullup <= 8'h00;
			portk_pullup <= 8'h00;
			pwm_port_pullup <= 8'h00;
			serial_port_pullup <= 8'h00;
			timer_port_pullup <= 8'h00;
			bus_port_pullup <= 8'h00;
		end
		else
		begin
			porta_pullup <= porta_pullup_nxt;
			portb_pullup <= portb_pullup_nxt;
			porte_pullup <= porte_pullup_nxt;
			porth_pullup <= porth_pullup_nxt;
			portj_pullup <= portj_pullup_nxt;
			portk_pullup <= portk_pullup_nxt;
			pwm_port_pullup <= pwm_port_pullup_nxt;
			serial_port_pullup <= serial_port_pullup_nxt;
			timer_port_pullup <= timer_port_pullup_nxt;
			bus_port_pullup <= bus_port_pullup_nxt;
		end
	end

endmodule // rrb_pad_ctrl

// ### hw/rrb_defines.vh
// Offsets, field positions, masks and reset values of the relocatable register block
`ifndef RRB_DEFINES_VH
`define RRB_DEFINES_VH

// Register indexes; byte address on the bus is four times the index
`define RRB_IDX_PULLUP_ENABLE 8'h0C
`define RRB_IDX_DRIVE_STRENGTH_SELECT 8'h0D
`define RRB_IDX_BLOCK_BASE_SELECT 8'h11
`define RRB_IDX_PWM_PORT_CONTROL 8'h54
`define RRB_IDX_TIMER_MASK_TWO 8'h8D
`define RRB_IDX_SERIAL_PORT_CONTROL_TWO 8'hD1
`define RRB_IDX_BUS_PORT_PULL_DRIVE 8'hE5

// Field positions shared by pullup_enable and drive_strength_select
`define RRB_BIT_PORTA 0
`define RRB_BIT_PORTB 1
`define RRB_BIT_PORTE 4
`define RRB_BIT_PORTH 5
`define RRB_BIT_PORTJ 6
`define RRB_BIT_PORTK 7

// block_base_select fields
`define RRB_BASE_HI 7
`define RRB_BASE_LO 3
`define RRB_BIT_MMSWAI 0

// pwm_port_control fields
`define RRB_BIT_PWM_WEAK 2
`define RRB_BIT_PWM_PULLUP 1

// timer_mask_two fields
`define RRB_BIT_TMR_PULLUP 5
`define RRB_BIT_TMR_WEAK 4

// serial_port_control_two fields
`define RRB_BIT_SER_PULLUP 3
`define RRB_BIT_SER_WEAK 2

// bus_port_pull_drive fields
`define RRB_BIT_BUS_PULLUP 1
`define RRB_BIT_BUS_WEAK 0

// Implemented-bit masks
`define RRB_MASK_PULLUP_ENABLE 8'hF3
`define RRB_MASK_DRIVE_STRENGTH 8'hF3
`define RRB_MASK_BLOCK_BASE 8'hF9
`define RRB_MASK_PWM_PORT 8'h1F
`define RRB_MASK_TIMER_MASK_TWO 8'h30
`define RRB_MASK_SERIAL_PORT_TWO 8'h0C
`define RRB_MASK_BUS_PORT 8'h03

// Reset values
`define RRB_RST_PULLUP_ENABLE 8'h10
`define RRB_RST_DRIVE_STRENGTH 8'h00
`define RRB_RST_BLOCK_BASE 8'h00
`define RRB_RST_PWM_PORT 8'h00
`define RRB_RST_TIMER_MASK_TWO 8'h00
`define RRB_RST_SERIAL_PORT_TWO 8'h08
`define RRB_RST_BUS_PORT 8'h00

`endif

// ### tb/rrb_pad_ctrl_sva.sv
// Checker for block decode and pad control outputs
module rrb_pad_ctrl_sva
(
	input wire mclk, // Clock
	input wire rst_n, // Reset, active low
	input wire avs_read, // Read request
	input wire avs_write, // Write request
	input wire avs_waitrequest, // Stall
	input wire [15:0] cpu_addr, // Decoded address
	input wire reg_block_sel, // Block hit
	input wire [9:0] reg_block_offset, // Block offset
	input wire [7:0] porta_dir, // Port A direction
	input wire [7:0] porte_dir, // Port E direction
	input wire [7:0] serial_port_dir, // Serial direction
	input wire [7:0] bus_port_dir, // Bus port direction
	input wire [7:0] porta_pullup, // Port A pulls
	input wire [7:0] porte_pullup, // Port E pulls
	input wire [7:0] serial_port_pullup, // Serial pulls
	input wire [7:0] bus_port_pullup, // Bus port pulls
	input wire porta_weak_drive, // Port A drive
	input wire serial_port_weak_drive // Serial drive
);
	// All checks on the one clock, off during reset
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_upper_half_off: assert property (reg_block_sel |-> !cpu_addr[10])
		else $error("block selected in upper half");
	a_offset_low_bits: assert property (reg_block_offset == cpu_addr[9:0])
		else $error("offset differs from low address");
	a_base_holds: assert property ($past(rst_n) && !$past(avs_write) && $stable(cpu_addr)
		|-> $stable(reg_block_sel)) else $error("decode moved without a write");
	a_base_after_reset: assert property (!$past(rst_n) && cpu_addr[15:10] == 6'h00
		|-> reg_block_sel) else $error("block not at zero after reset");
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("waitrequest held too long");
	a_serial_out_nopull: assert property ((serial_port_pullup & $past(serial_port_dir)) == 8'h00)
		else $error("pull-up on serial output");
	a_input_only_pull: assert property (((porta_pullup & $past(porta_dir))
		| (porte_pullup & $past(porte_dir) & 8'h8c)) == 8'h00) else $error("pull-up on output");
	a_bus_low_pull: assert property ($past(rst_n)
		|-> bus_port_pullup[3:2] == ~$past(bus_port_dir[3:2])) else $error("bus low pins pull");
	a_reset_pulls: assert property ($rose(rst_n) |=> porta_pullup == 8'h00
		&& serial_port_pullup == ~$past(serial_port_dir)
		&& porte_pullup == {~$past(porte_dir[7]), 3'b000, ~$past(porte_dir[3:2]), 2'b11})
		else $error("pull-ups wrong after reset");
	a_full_drive_reset: assert property (!$past(rst_n)
		|-> !porta_weak_drive && !serial_port_weak_drive) else $error("reduced drive at reset");
endmodule // rrb_pad_ctrl_sva

bind rrb_pad_ctrl rrb_pad_ctrl_sva chk_u (.*);

// ### tb/test_relocatable_register_block_pad_control.sv
// Self-checking bench for the relocatable register block and pad controls
module test_relocatable_register_block_pad_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, reg_block_sel, mem_map_stop_wait;
	logic [7:0] avs_address, porta_dir, portb_dir, porte_dir, porth_dir, portj_dir, portk_dir;
	logic [7:0] pwm_port_dir, serial_port_dir, timer_port_dir, bus_port_dir, porta_pullup;
	logic [7:0] portb_pullup, porte_pullup, porth_pullup, portj_pullup, portk_pullup;
	logic [7:0] pwm_port_pullup, serial_port_pullup, timer_port_pullup, bus_port_pullup;
	logic porta_weak_drive, portb_weak_drive, porte_weak_drive, porth_weak_drive;
	logic portj_weak_drive, portk_weak_drive, pwm_port_weak_drive, serial_port_weak_drive;
	logic timer_port_weak_drive, bus_port_weak_drive;
	logic [31:0] avs_writedata, avs_readdata, seed, q;
	logic [3:0] avs_byteenable;
	logic [15:0] cpu_addr;
	logic [9:0] reg_block_offset;
	int err_count, total_checks, k, i;
	// Register index, implemented bits and reset value, table order
	logic [7:0] v[7];
	logic [7:0] ix[7] = '{8'h0c, 8'h0d, 8'h11, 8'h54, 8'h8d, 8'hd1, 8'he5};
	logic [7:0] mk[7] = '{8'hf3, 8'hf3, 8'hf9, 8'h1f, 8'h30, 8'h0c, 8'h03};
	logic [7:0] rv[7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};

	rrb_pad_ctrl dut_u (.*);

	// Repeatable random source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Pull-up seen on a port: only input pins when enabled
	function automatic logic [7:0] pull(input logic en, input logic [7:0] dir);
		return en ? ~dir : 8'h00;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; holds the request until waitrequest is low
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		// Only the watchdog ends a wait that never finishes
		do
		begin
			@(posedge mclk);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic reset_checks();
		for (k = 0; k < 7; k++)
		begin
			bus(1'b0, ix[k], 8'h00);
			chk(q, {24'h00_0000, rv[k]});
		end
		cpu_addr <= 16'h03ff;
		@(posedge mclk);
		chk(reg_block_sel, 1'b1);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Clock, 100 ns period
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Hang guard
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_count++;
		close_out();
	end

	// Main sequence
	initial
	begin
		{rst_n, avs_read, avs_write, avs_address, avs_writedata, cpu_addr} = '0;
		{porta_dir, portb_dir, porte_dir, porth_dir, portj_dir} = '0;
		{portk_dir, pwm_port_dir, serial_port_dir, timer_port_dir, bus_port_dir} = '0;
		{seed, err_count, total_checks, avs_byteenable} = {32'h0000_0006, 64'h0, 4'hf};
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		reset_checks();
		$display("test reset values done");
		for (i = 0; i < 12; i++)
		begin
			for (k = 0; k < 7; k++)
			begin
				q = rnd();
				v[k] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : q[7:0];
				bus(1'b1, ix[k], v[k]);
			end
			for (k = 0; k < 7; k++)
			begin
				bus(1'b0, ix[k], 8'h00);
				chk(q, {24'h00_0000, v[k] & mk[k]});
			end
			// Lane 0 off: the write must be ignored
			avs_byteenable <= 4'he;
			bus(1'b1, ix[0], ~v[0]);
			avs_byteenable <= 4'hf;
			bus(1'b0, ix[0], 8'h00);
			chk(q, {24'h00_0000, v[0] & mk[0]});
			// Unmapped index: write dropped, read gives zero
			bus(1'b1, 8'h00, 8'hff);
			bus(1'b0, 8'h00, 8'h00);
			chk(q, 32'h0000_0000);
			q = rnd();
			{porta_dir, portb_dir, porte_dir, porth_dir} <= q;
			q = rnd();
			{portj_dir, portk_dir, pwm_port_dir, serial_port_dir} <= q;
			q = rnd();
			{timer_port_dir, bus_port_dir} <= q[15:0];
			repeat (2) @(posedge mclk);
			chk(porta_pullup, pull(v[0][0], porta_dir));
			chk(portb_pullup, pull(v[0][1], portb_dir));
			chk(porth_pullup, pull(v[0][5], porth_dir));
			chk(portj_pullup, pull(v[0][6], portj_dir));
			chk(pwm_port_pullup, pull(v[3][1], pwm_port_dir));
			chk(portk_pullup, pull(v[0][7], portk_dir) & 8'h8f);
			chk(porte_pullup, pull(v[0][4], {porte_dir[7], 3'b111, porte_dir[3:2], 2'b00}));
			chk(serial_port_pullup, pull(v[5][3], serial_port_dir));
			chk(timer_port_pullup, pull(v[4][5], timer_port_dir));
			chk(bus_port_pullup,
				(pull(v[6][1], bus_port_dir) & 8'hf0) | (~bus_port_dir & 8'h0c));
			chk({portk_weak_drive, portj_weak_drive, porth_weak_drive, porte_weak_drive,
				portb_weak_drive, porta_weak_drive}, {v[1][7:4], v[1][1:0]});
			chk({pwm_port_weak_drive, timer_port_weak_drive, serial_port_weak_drive,
				bus_port_weak_drive}, {v[3][2], v[4][4], v[5][2], v[6][0]});
			chk(mem_map_stop_wait, v[2][0]);
			for (k = 0; k < 3; k++)
			begin
				q = rnd();
				cpu_addr <= {v[2][7:3] ^ ((k == 2) ? 5'h01 : 5'h00), k[0], q[9:0]};
				@(posedge mclk);
				chk(reg_block_sel, k == 0);
				chk(reg_block_offset, q[9:0]);
			end
			$display("test pass %0d done", i);
		end
		rst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		reset_checks();
		$display("test second reset done");
		close_out();
	end
endmodule // test_relocatable_register_block_pad_control
